// ==== hidden_reg_pkg.sv ====
/*
 * Shared constants for the hidden register bank: aux mode register decode,
 * hidden selector codes, reset values, field positions and settle timing.
 * Assumes a single 100 MHz system clock.
 */
package hidden_reg_pkg;
   localparam int          CLK_MHZ          = 100;
   localparam logic [11:0] AUX_MODE_OFFSET  = 12'h11b;
   localparam int          SEL_MSB          = 7;
   localparam int          SEL_LSB          = 5;
   localparam logic [2:0]  SEL_DELAY_DIV    = 3'h1;
   localparam logic [2:0]  SEL_POLL_RESP    = 3'h3;
   localparam logic [3:0]  DELAY_DIV_RESET  = 4'h8;
   localparam logic [4:0]  POLL_RESP_RESET  = 5'h10;
   localparam int          U_BIT            = 4;
   localparam int          S_BIT            = 3;
   // One divider step lasts this long; least time, so round up
   localparam int          UNIT_NS          = 100;
   localparam int          UNIT_CYC         = (UNIT_NS * CLK_MHZ + 999) / 1000;
   localparam logic [1:0]  SLOW_MULT        = 2'h2;
endpackage : hidden_reg_pkg

// ==== settle_delay_timer.sv ====
/*
 * Source settle delay timer: after a byte is placed on the data lines,
 * counts div x multiplier units of UNIT_CYC clocks, then raises settled.
 * Assumes start is a one-cycle pulse from logic on the same clock.
 */
module settle_delay_timer
   import hidden_reg_pkg::*;
#(
   parameter int DIV_W = 4,
   parameter int UCYC  = UNIT_CYC
) (
   input  wire logic             i_sys_clk,
   input  wire logic             i_nrst,
   input  wire logic             i_start,
   input  wire logic             i_slow,
   input  wire logic [DIV_W-1:0] i_div,
   output logic                  o_settled
);
   logic [DIV_W:0] units;
   logic [DIV_W:0] next_units;
   logic [7:0]     pre;
   logic [7:0]     next_pre;
   logic           next_settled;
   logic [DIV_W:0] load;

   always_comb begin
      // Zero divider would leave settled low forever after start; hold it to one unit
      load = (i_div == '0) ? (DIV_W+1)'(1) : {1'b0, i_div};
      if (i_slow) begin
         load = (DIV_W+1)'(load * SLOW_MULT);
      end
      next_units   = units;
      next_pre     = pre;
      next_settled = o_settled;
      if (i_start) begin
         next_units   = load;
         next_pre     = 8'(UCYC - 1);
         next_settled = 1'b0;
      end else if (!o_settled && units != '0) begin
         if (pre == 8'h00) begin
            next_pre = 8'(UCYC - 1);
            if (units == (DIV_W+1)'(1)) begin
               next_settled = 1'b1;
            end
            next_units = units - (DIV_W+1)'(1);
         end else begin
            next_pre = pre - 8'h01;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         units     <= '0;
         pre       <= 8'h00;
         o_settled <= 1'b1;
      end else begin
         units     <= next_units;
         pre       <= next_pre;
         o_settled <= next_settled;
      end
   end
endmodule : settle_delay_timer

// ==== poll_line_driver.sv ====
/*
 * Parallel poll line driver: while a poll is in progress, pulls the one
 * data line named by the response code when status matches sense.
 * Assumes idy is already synchronised to the system clock.
 */
module poll_line_driver
   import hidden_reg_pkg::*;
(
   input  wire logic       i_sys_clk,
   input  wire logic       i_nrst,
   input  wire logic       i_idy,
   input  wire logic       i_ist,
   input  wire logic [4:0] i_cfg,
   output logic [7:0]      o_oe,
   output logic            o_active
);
   logic [7:0] next_oe;
   logic       next_active;

   always_comb begin
      next_oe     = 8'h00;
      next_active = 1'b0;
      // Unconfigured devices stay off the lines entirely
      if (i_idy && !i_cfg[U_BIT] && (i_ist == i_cfg[S_BIT])) begin
         next_oe     = 8'h01 << i_cfg[2:0];
         next_active = 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         o_oe     <= 8'h00;
         o_active <= 1'b0;
      end else begin
         o_oe     <= next_oe;
         o_active <= next_active;
      end
   end
endmodule : poll_line_driver

// ==== hidden_reg_poll_config.sv ====
/*
 * Hidden register bank of the talker listener controller chip: the delay
 * divider and poll response registers, loaded through the aux mode
 * register, plus the settle delay timer and parallel poll response.
 * Assumes the bus write port, chip reset, power-on and remote poll
 * messages come from logic on i_sys_clk; attention and end-or-identify
 * arrive from pins and are synchronised here.
 */
// Contract
// - A write to the aux mode register uses bits 7-5 as hidden selector and bits 4-0 as data.
// - Hidden registers are not readable and return to initial values only by chip reset or power-on.
// - Selector 001 loads the data field into the delay divider register.
// - The low four divider bits scale the counters that time bus state changes.
// - The source settle delay before data valid depends on transfer type and three-state timing.
// - Divider eight gives over 700 ns settle; five gives 500 ns during writes, then back to eight.
// - Selector 011 loads the data field into the poll response register.
// - The poll response register contents decide how the device answers a parallel poll.
// - In remote configuration the device handles configure, enable, disable and identify on its own.
// - Disable bit 0 takes part in polls, disable bit 1 does not respond.
// - The assigned line is driven low only when status equals the sense bit.
// - The three line-select bits give line number minus one.
module hidden_reg_poll_config
   import hidden_reg_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_bus_wr,
   input  wire logic [11:0] i_bus_addr,
   input  wire logic [7:0]  i_bus_wdata,
   input  wire logic        i_chip_reset,
   input  wire logic        i_pon,
   input  wire logic        i_ist,
   input  wire logic        i_pp_remote,
   input  wire logic        i_rx_ppc,
   input  wire logic        i_rx_other_cmd,
   input  wire logic        i_rx_ppe,
   input  wire logic        i_rx_ppd,
   input  wire logic [3:0]  i_rx_cmd_low,
   input  wire logic        i_atn_n,
   input  wire logic        i_eoi_n,
   input  wire logic        i_src_start,
   input  wire logic        i_src_command,
   input  wire logic        i_tri_timing,
   output logic             o_source_settled,
   output logic [7:0]       o_dio_oe,
   output logic [7:0]       o_dio_out,
   output logic             o_poll_active
);
   logic [3:0] delay_div;
   logic [3:0] next_delay_div;
   logic [4:0] poll_resp;
   logic [4:0] next_poll_resp;
   logic       pacs;
   logic       next_pacs;
   logic       atn_s1;
   logic       atn_s2;
   logic       eoi_s1;
   logic       eoi_s2;
   logic       aux_hit;
   logic [2:0] hidden_selector;
   logic [4:0] hidden_data_field;
   logic       restore;
   logic       idy;
   logic       slow;

   // Pin synchronisers; only the second stage is looked at
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         atn_s1 <= 1'b1;
         atn_s2 <= 1'b1;
         eoi_s1 <= 1'b1;
         eoi_s2 <= 1'b1;
      end else begin
         atn_s1 <= i_atn_n;
         atn_s2 <= atn_s1;
         eoi_s1 <= i_eoi_n;
         eoi_s2 <= eoi_s1;
      end
   end

   always_comb begin
      idy               = !atn_s2 && !eoi_s2;
      aux_hit           = i_bus_wr && (i_bus_addr == AUX_MODE_OFFSET);
      hidden_selector   = i_bus_wdata[SEL_MSB:SEL_LSB];
      hidden_data_field = i_bus_wdata[4:0];
      restore           = i_chip_reset || i_pon;
      // Commands and any non-fast-data transfer take the long settle
      slow              = i_src_command || !i_tri_timing;
   end

   // Hidden register loads; there is no read path at all
   always_comb begin
      next_delay_div = delay_div;
      next_poll_resp = poll_resp;
      next_pacs      = pacs;
      if (restore) begin
         next_delay_div = DELAY_DIV_RESET;
         next_poll_resp = POLL_RESP_RESET;
         next_pacs      = 1'b0;
      end else begin
         if (aux_hit && hidden_selector == SEL_DELAY_DIV) begin
            // Reserved bit 4 is dropped, never stored
            next_delay_div = hidden_data_field[3:0];
         end
         if (aux_hit && hidden_selector == SEL_POLL_RESP) begin
            // Still stored in remote mode; that clobbers the remote setup
            next_poll_resp = hidden_data_field;
         end
         if (i_pp_remote) begin
            if (i_rx_ppc) begin
               next_pacs = 1'b1;
            end else if (i_rx_other_cmd) begin
               next_pacs = 1'b0;
            end
            if (pacs && i_rx_ppe) begin
               next_poll_resp = {1'b0, i_rx_cmd_low};
            end else if (pacs && i_rx_ppd) begin
               next_poll_resp = POLL_RESP_RESET;
            end
         end else begin
            next_pacs = 1'b0;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         delay_div <= DELAY_DIV_RESET;
         poll_resp <= POLL_RESP_RESET;
         pacs      <= 1'b0;
         o_dio_out <= 8'h00;
      end else begin
         delay_div <= next_delay_div;
         poll_resp <= next_poll_resp;
         pacs      <= next_pacs;
         // Open-collector style: data is always low, enable does the work
         o_dio_out <= 8'h00;
      end
   end

   settle_delay_timer #(
      .DIV_W (4),
      .UCYC  (UNIT_CYC)
   ) u_settle (
      .i_sys_clk (i_sys_clk),
      .i_nrst    (i_nrst),
      .i_start   (i_src_start),
      .i_slow    (slow),
      .i_div     (delay_div),
      .o_settled (o_source_settled)
   );

   poll_line_driver u_poll (
      .i_sys_clk (i_sys_clk),
      .i_nrst    (i_nrst),
      .i_idy     (idy),
      .i_ist     (i_ist),
      .i_cfg     (poll_resp),
      .o_oe      (o_dio_oe),
      .o_active  (o_poll_active)
   );

   sequence s_fast_settle8;
      ##[75:85] o_source_settled;
   endsequence

   sequence s_fast_settle5;
      ##[45:55] o_source_settled;
   endsequence

   sequence s_slow_settle8;
      ##[155:165] o_source_settled;
   endsequence

   property p_sel_delay;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (aux_hit && hidden_selector == SEL_DELAY_DIV && !restore)
         |=> delay_div == $past(i_bus_wdata[3:0]);
   endproperty
   a_sel_delay: assert property (p_sel_delay) else $error("divider not loaded");

   property p_sel_poll;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (aux_hit && hidden_selector == SEL_POLL_RESP && !restore && !i_pp_remote)
         |=> poll_resp == $past(i_bus_wdata[4:0]);
   endproperty
   a_sel_poll: assert property (p_sel_poll) else $error("poll register not loaded");

   property p_other_sel;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (aux_hit && hidden_selector != SEL_DELAY_DIV && !restore) |=> $stable(delay_div);
   endproperty
   a_other_sel: assert property (p_other_sel) else $error("wrong selector hit divider");

   property p_restore;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      restore |=> (delay_div == DELAY_DIV_RESET && poll_resp == POLL_RESP_RESET);
   endproperty
   a_restore: assert property (p_restore) else $error("restore failed");

   property p_fast8;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_src_start && delay_div == 4'h8 && !slow) |=> !o_source_settled ##0 s_fast_settle8;
   endproperty
   a_fast8: assert property (p_fast8) else $error("settle at eight wrong");

   property p_fast5;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_src_start && delay_div == 4'h5 && !slow) |=> !o_source_settled ##0 s_fast_settle5;
   endproperty
   a_fast5: assert property (p_fast5) else $error("settle at five wrong");

   property p_slow8;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_src_start && delay_div == 4'h8 && slow) |=> !o_source_settled ##0 s_slow_settle8;
   endproperty
   a_slow8: assert property (p_slow8) else $error("slow settle wrong");

   property p_unconf;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      poll_resp[U_BIT] |=> o_dio_oe == 8'h00;
   endproperty
   a_unconf: assert property (p_unconf) else $error("unconfigured device drove line");

   property p_sense_mismatch;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (idy && i_ist != poll_resp[S_BIT]) |=> o_dio_oe == 8'h00;
   endproperty
   a_sense_mismatch: assert property (p_sense_mismatch) else $error("line driven against sense");

   property p_line_select;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (idy && !poll_resp[U_BIT] && i_ist == poll_resp[S_BIT])
         |=> (o_dio_oe == (8'h01 << $past(poll_resp[2:0])) && o_poll_active);
   endproperty
   a_line_select: assert property (p_line_select) else $error("wrong poll line");

   property p_remote_ppe;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_pp_remote && pacs && i_rx_ppe && !restore && !aux_hit)
         |=> poll_resp == {1'b0, $past(i_rx_cmd_low)};
   endproperty
   a_remote_ppe: assert property (p_remote_ppe) else $error("remote enable not taken");

   property p_remote_ppd;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_pp_remote && pacs && i_rx_ppd && !i_rx_ppe && !restore && !aux_hit)
         |=> poll_resp == POLL_RESP_RESET;
   endproperty
   a_remote_ppd: assert property (p_remote_ppd) else $error("remote disable not taken");

   sequence s_slow_settle5;
      ##[95:105] o_source_settled;
   endsequence

   property p_slow5;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_src_start && delay_div == 4'h5 && slow) |=> !o_source_settled ##0 s_slow_settle5;
   endproperty
   a_slow5: assert property (p_slow5) else $error("slow settle at five wrong");

   property p_start_drop;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      i_src_start |=> !o_source_settled;
   endproperty
   a_start_drop: assert property (p_start_drop) else $error("settled not dropped on start");

   property p_pacs_enter;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_pp_remote && i_rx_ppc && !restore) |=> pacs;
   endproperty
   a_pacs_enter: assert property (p_pacs_enter) else $error("configure state not entered");

   property p_pacs_local;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      !i_pp_remote |=> !pacs;
   endproperty
   a_pacs_local: assert property (p_pacs_local) else $error("configure state in local mode");

   property p_div_hold;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (!restore && !aux_hit) |=> $stable(delay_div);
   endproperty
   a_div_hold: assert property (p_div_hold) else $error("divider changed without write");

   property p_resp_hold;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (!restore && !aux_hit && !(i_pp_remote && pacs && (i_rx_ppe || i_rx_ppd)))
         |=> $stable(poll_resp);
   endproperty
   a_resp_hold: assert property (p_resp_hold) else $error("poll register changed unasked");

   property p_idle_off;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      !idy |=> (o_dio_oe == 8'h00 && !o_poll_active);
   endproperty
   a_idle_off: assert property (p_idle_off) else $error("line driven outside poll");

   property p_one_line;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      $onehot0(o_dio_oe);
   endproperty
   a_one_line: assert property (p_one_line) else $error("more than one poll line");

endmodule : hidden_reg_poll_config

// ==== poll_ctrl_model.sv ====
/*
 * Controller in charge model: conducts parallel polls on attention and
 * end-or-identify, and sends remote poll configure messages.
 * Assumes the bench calls its tasks from the i_sys_clk domain.
 */
module poll_ctrl_model (
   input  wire logic       i_sys_clk,
   input  wire logic [7:0] i_dio_oe,
   output logic            o_atn_n,
   output logic            o_eoi_n,
   output logic            o_rx_ppc,
   output logic            o_rx_other_cmd,
   output logic            o_rx_ppe,
   output logic            o_rx_ppd,
   output logic [3:0]      o_rx_cmd_low
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_atn_n = 1'b1;
      o_eoi_n = 1'b1;
      o_rx_ppc = 1'b0;
      o_rx_other_cmd = 1'b0;
      o_rx_ppe = 1'b0;
      o_rx_ppd = 1'b0;
      o_rx_cmd_low = 4'h0;
   end
   // Hold sets prompt or slow polls; released pins are driven high again by the model
   task automatic do_poll(input int hold, output logic [7:0] resp, output logic [7:0] after);
      @(posedge i_sys_clk);
      o_atn_n <= 1'b0;
      o_eoi_n <= 1'b0;
      repeat (hold) @(posedge i_sys_clk);
      #1 resp = i_dio_oe;
      @(posedge i_sys_clk);
      o_atn_n <= 1'b1;
      o_eoi_n <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      #1 after = i_dio_oe;
   endtask : do_poll
   // Kind: 0 configure, 1 enable, 2 disable, 3 other command
   task automatic send_msg(input logic [1:0] kind, input logic [3:0] low);
      @(posedge i_sys_clk);
      o_rx_ppc <= (kind == 2'h0);
      o_rx_ppe <= (kind == 2'h1);
      o_rx_ppd <= (kind == 2'h2);
      o_rx_other_cmd <= (kind == 2'h3);
      o_rx_cmd_low <= low;
      @(posedge i_sys_clk);
      o_rx_ppc <= 1'b0;
      o_rx_ppe <= 1'b0;
      o_rx_ppd <= 1'b0;
      o_rx_other_cmd <= 1'b0;
      o_rx_cmd_low <= ~low;
   endtask : send_msg
endmodule : poll_ctrl_model

// ==== tb_top.sv ====
/*
 * Self-checking bench for the hidden register bank: settle timing,
 * register decode, restore, local and remote parallel poll response.
 * Assumes the partner model stands in for the bus controller.
 */
module tb_top
   import hidden_reg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk, nrst, bus_wr, chip_reset, pon, ist, pp_remote;
   logic        src_start, src_command, tri_timing, settled, poll_active;
   logic [11:0] bus_addr;
   logic [7:0]  bus_wdata, dio_oe, dio_out;
   logic        atn_n, eoi_n, rx_ppc, rx_other_cmd, rx_ppe, rx_ppd;
   logic [3:0]  rx_cmd_low;
   int          n_fail, samples_checked, cyc;
   hidden_reg_poll_config dut_u (.i_sys_clk(sys_clk), .i_nrst(nrst), .i_bus_wr(bus_wr),
      .i_bus_addr(bus_addr), .i_bus_wdata(bus_wdata), .i_chip_reset(chip_reset), .i_pon(pon),
      .i_ist(ist), .i_pp_remote(pp_remote), .i_rx_ppc(rx_ppc), .i_rx_other_cmd(rx_other_cmd),
      .i_rx_ppe(rx_ppe), .i_rx_ppd(rx_ppd), .i_rx_cmd_low(rx_cmd_low), .i_atn_n(atn_n),
      .i_eoi_n(eoi_n), .i_src_start(src_start), .i_src_command(src_command),
      .i_tri_timing(tri_timing), .o_source_settled(settled), .o_dio_oe(dio_oe),
      .o_dio_out(dio_out), .o_poll_active(poll_active));
   poll_ctrl_model ctrl_u (.i_sys_clk(sys_clk), .i_dio_oe(dio_oe), .o_atn_n(atn_n),
      .o_eoi_n(eoi_n), .o_rx_ppc(rx_ppc), .o_rx_other_cmd(rx_other_cmd), .o_rx_ppe(rx_ppe),
      .o_rx_ppd(rx_ppd), .o_rx_cmd_low(rx_cmd_low));
   always #5 sys_clk = ~sys_clk;
   task automatic finish_test();
      $display("checks=%0d failures=%0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Reserved divider bit always written as zero by callers
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge sys_clk);
      bus_wr <= 1'b0;
      bus_wdata <= ~d;
   endtask : wr
   task automatic settle(input int units);
      int n;
      @(posedge sys_clk);
      src_start <= 1'b1;
      @(posedge sys_clk);
      src_start <= 1'b0;
      @(posedge sys_clk);
      #1 chk({7'h0, settled}, 8'h00);
      n = 0;
      while (settled !== 1'b1 && n < 400) begin
         @(posedge sys_clk);
         #1 n++;
      end
      chk({7'h0, n >= units * UNIT_CYC - 3 && n <= units * UNIT_CYC + 2}, 8'h01);
   endtask : settle
   task automatic poll(input int hold, input logic [7:0] exp);
      logic [7:0] r, a;
      logic       act;
      // Active flag sampled at the same instant as the line enables
      fork
         ctrl_u.do_poll(hold, r, a);
         begin
            repeat (hold + 1) @(posedge sys_clk);
            #1 act = poll_active;
         end
      join
      chk(r, exp);
      chk(a, 8'h00);
      chk({7'h0, act}, {7'h0, exp != 8'h00});
      chk({7'h0, poll_active}, 8'h00);
      chk(dio_out, 8'h00);
   endtask : poll
   task automatic set_ist(input logic v);
      @(posedge sys_clk);
      ist <= v;
   endtask : set_ist
   task automatic t_divider();
      settle(8);
      wr(AUX_MODE_OFFSET, {SEL_DELAY_DIV, 5'h05});
      settle(5);
      @(posedge sys_clk);
      src_command <= 1'b1;
      settle(10);
      @(posedge sys_clk);
      src_command <= 1'b0;
      tri_timing <= 1'b0;
      settle(10);
      @(posedge sys_clk);
      tri_timing <= 1'b1;
      wr(AUX_MODE_OFFSET, {SEL_DELAY_DIV, 5'h08});
      settle(8);
      @(posedge sys_clk);
      src_command <= 1'b1;
      settle(16);
      @(posedge sys_clk);
      src_command <= 1'b0;
      wr(12'h11a, {SEL_DELAY_DIV, 5'h02});
      wr(AUX_MODE_OFFSET, {3'h2, 5'h02});
      settle(8);
   endtask : t_divider
   task automatic t_local_poll();
      set_ist(1'b1);
      poll(6, 8'h00);
      for (int p = 0; p < 8; p++) begin
         wr(AUX_MODE_OFFSET, {SEL_POLL_RESP, 2'b01, 3'(p)});
         set_ist(1'b1);
         poll(6, 8'h01 << p);
         set_ist(1'b0);
         poll(6, 8'h00);
      end
      wr(AUX_MODE_OFFSET, {SEL_POLL_RESP, 5'h00});
      poll(20, 8'h01);
      set_ist(1'b1);
      poll(6, 8'h00);
      wr(AUX_MODE_OFFSET, {SEL_POLL_RESP, 5'h10});
      poll(6, 8'h00);
   endtask : t_local_poll
   task automatic t_restore();
      for (int k = 0; k < 2; k++) begin
         wr(AUX_MODE_OFFSET, {SEL_DELAY_DIV, 5'h05});
         wr(AUX_MODE_OFFSET, {SEL_POLL_RESP, 5'h09});
         @(posedge sys_clk);
         chip_reset <= (k == 0);
         pon <= (k == 1);
         @(posedge sys_clk);
         chip_reset <= 1'b0;
         pon <= 1'b0;
         settle(8);
         poll(6, 8'h00);
      end
   endtask : t_restore
   // No software write to the poll register while remote
   task automatic t_remote();
      @(posedge sys_clk);
      pp_remote <= 1'b1;
      ctrl_u.send_msg(2'h0, 4'h0);
      ctrl_u.send_msg(2'h1, 4'hd);
      poll(6, 8'h20);
      ctrl_u.send_msg(2'h2, 4'h0);
      poll(6, 8'h00);
      // Leaving the configure state must make later enables ignored
      ctrl_u.send_msg(2'h3, 4'h0);
      ctrl_u.send_msg(2'h1, 4'h9);
      poll(6, 8'h00);
   endtask : t_remote
   initial begin
      sys_clk = 1'b0;
      nrst = 1'b0;
      bus_wr = 1'b0;
      bus_addr = 12'h000;
      bus_wdata = 8'h00;
      chip_reset = 1'b0;
      pon = 1'b0;
      ist = 1'b0;
      pp_remote = 1'b0;
      src_start = 1'b0;
      src_command = 1'b0;
      tri_timing = 1'b1;
      n_fail = 0;
      samples_checked = 0;
      cyc = 0;
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      t_divider();
      t_local_poll();
      t_restore();
      t_remote();
      finish_test();
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         finish_test();
      end
   end
endmodule : tb_top
